// File: phy_ext_page2_defines.vh
// constants for the extended page 2 control register bank
// assumes a 200 mhz aclk and an axi4-lite master on the register side
`ifndef PHY_EXT_PAGE2_DEFINES_VH
`define PHY_EXT_PAGE2_DEFINES_VH

// ****************************************************************
// bus and register map (index; byte address is four times index)
// ****************************************************************
`define ADDR_W 8
`define IDX_BASIC 5'h00
`define IDX_EEE 5'h11
`define IDX_CAP 5'h12
`define IDX_ENT 5'h13
`define IDX_MASK 5'h1C
`define IDX_STAT 5'h1D
`define IDX_PAGE 5'h1F
`define IDX_EXT_LO 5'h10
`define IDX_EXT_HI 5'h1E
`define PAGE_MAIN 16'h0000
`define PAGE_EXT2 16'h0002
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************************************
// control register field positions
// ****************************************************************
`define EEE_TE_BIT 15
`define EEE_LED_UNI_BIT 14
`define EEE_POL_HI 13
`define EEE_POL_LO 10
`define EEE_LINK_BIT 8
`define EEE_EN1000_BIT 7
`define EEE_EN100_BIT 6
`define EEE_FORCE1000_BIT 5
`define EEE_FORCE_LPI_BIT 4
`define EEE_INH100_TX_BIT 3
`define EEE_INH100_RX_BIT 2
`define EEE_INH1000_TX_BIT 1
`define EEE_INH1000_RX_BIT 0
`define EEE_WR_MASK 16'hFC3F
`define EEE_RESET 16'h0000

// basic control register: speed select and software reset
`define BASIC_SOFT_RST_BIT 15
`define BASIC_SPD_MSB_BIT 6
`define BASIC_SPD_LSB_BIT 13
`define BASIC_RESET 16'h0040
`define SPEED_1000 2'h2

// ****************************************************************
// capability word, interrupt mask and status
// ****************************************************************
`define CAP_TEMP_BIT 15
`define CAP_QUAD_BIT 14
`define CAP_SEC_BIT 12
`define CAP_DUAL_BIT 10
`define CAP_KEY256_BIT 8
`define CAP_QUAD_VAL 1'b0
`define MASK_RESET 16'h0000
`define INT_W 11
`define STAT_RESET 11'h000

// link modes reported by the speed logic
`define LINK_MODE_10 2'h0
`define LINK_MODE_100 2'h1
`define LINK_MODE_1000 2'h2

// entropy generator
`define LFSR_SEED 16'hACE1
`define LFSR_TAPS 16'hB400

`endif

// File: entropy_lfsr.v
// free-running galois lfsr used as the entropy source
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "phy_ext_page2_defines.vh"

module entropy_lfsr #(
  parameter WIDTH = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] noise,
  output wire [WIDTH-1:0] value
);

  reg [WIDTH-1:0] state_reg;
  wire [WIDTH-1:0] state_next;

  // shift right, fold taps in when the low bit falls out, mix noise
  assign state_next = ((state_reg >> 1) ^
    (state_reg[0] ? `LFSR_TAPS : {WIDTH{1'b0}})) ^ noise;

  // state never locks at zero since a zero next state reloads the seed
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= `LFSR_SEED;
    end else if (state_next == {WIDTH{1'b0}}) begin
      state_reg <= `LFSR_SEED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value = state_reg;

endmodule // entropy_lfsr
`default_nettype wire

// File: phy_ext_page2_ctrl_regs.v
// extended page 2 control bank: efficient ethernet debug control,
// capability word, entropy word, interrupt mask and pending status
// assumes an axi4-lite master and phy datapath logic on aclk
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "phy_ext_page2_defines.vh"

module phy_ext_page2_ctrl_regs #(
  parameter INDUSTRIAL_TEMP = 1'b0, // temperature grade strap
  parameter SEC_CAPABLE = 1'b1,
  parameter DUAL_MEDIA = 1'b1,
  parameter KEY256_CAPABLE = 1'b1,
  parameter [7:0] VARIANT_BCD = 8'h42 // arbitrary value
) (
  input wire aclk,
  input wire aresetn,
  // axi4-lite slave
  input wire [`ADDR_W-1:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  input wire [`ADDR_W-1:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // phy state from the datapath
  input wire link_up,
  input wire [1:0] link_mode,
  input wire eee_en_1000,
  input wire eee_en_100,
  input wire fiber_unidir,
  input wire mac_tx_lpi,
  input wire mdi_rx_lpi,
  input wire [`INT_W-1:0] int_events,
  input wire [7:0] indicator_raw,
  input wire serial_ind_data,
  input wire [1:0] serial_ind_group,
  // controls toward the datapath
  output wire enable_10base_te,
  output wire force_1000_no_ms,
  output wire generator_tx_lpi,
  output wire mdi_tx_lpi,
  output wire mac_rx_lpi,
  output wire soft_reset_pulse,
  output wire [7:0] indicator_outputs,
  output wire serial_ind_out,
  output wire irq
);

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [15:0] eee_ctrl_reg;
  reg [15:0] mask_reg;
  reg [`INT_W-1:0] stat_reg;
  reg [15:0] page_reg;
  reg [15:0] basic_reg;
  reg soft_rst_reg;
  reg awready_reg;
  reg wready_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [`ADDR_W-1:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg ten_reg;
  reg f1000_reg;
  reg gen_lpi_reg;
  reg tx_lpi_reg;
  reg rx_lpi_reg;
  reg [7:0] ind_reg;
  reg ser_reg;
  reg irq_reg;
  wire [15:0] entropy;

  // ****************************************************************
  // entropy source
  // ****************************************************************
  entropy_lfsr #(
    .WIDTH(16)
  ) u_entropy (
    .aclk(aclk),
    .aresetn(aresetn),
    .noise({indicator_raw, int_events[7:0]}),
    .value(entropy)
  );

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire page2_sel;
  wire [4:0] widx;
  wire [4:0] ridx;
  wire w_fire;
  wire r_fire;
  wire w_hit;
  wire r_hit;
  wire [15:0] wmask;
  wire [15:0] wval;

  // page 2 replaces 16-30 only while the page register holds 2
  assign page2_sel = (page_reg == `PAGE_EXT2);
  assign widx = waddr_reg[6:2];
  assign ridx = araddr[6:2];
  assign w_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign r_fire = arvalid & arready_reg;
  assign wmask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  // decode for an index; 0-15 never look at the page
  function hit_of;
    input [4:0] idx;
    input [`ADDR_W-1:0] addr;
    input p2;
    begin
      hit_of = 1'b0;
      if (addr[1:0] == 2'h0 && addr[`ADDR_W-1] == 1'b0) begin
        if (idx == `IDX_BASIC || idx == `IDX_PAGE) begin
          hit_of = 1'b1;
        end else if (p2) begin
          hit_of = (idx == `IDX_EEE) || (idx == `IDX_CAP) ||
            (idx == `IDX_ENT) || (idx == `IDX_MASK) ||
            (idx == `IDX_STAT);
        end
      end
    end
  endfunction

  assign w_hit = hit_of(widx, waddr_reg, page2_sel);
  assign r_hit = hit_of(ridx, araddr, page2_sel);

  // byte-lane merge of write data into a 16-bit register
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [15:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  assign wval = wdata_reg[15:0];

  // ****************************************************************
  // read data mux
  // ****************************************************************
  reg [15:0] rword;

  // selects the addressed word; status and state bits are live
  always @* begin
    rword = 16'h0000;
    case (ridx)
      `IDX_BASIC: rword = basic_reg;
      `IDX_PAGE: rword = page_reg;
      `IDX_EEE: begin
        rword = eee_ctrl_reg & `EEE_WR_MASK;
        rword[`EEE_LINK_BIT] = link_up;
        rword[`EEE_EN1000_BIT] = eee_en_1000;
        rword[`EEE_EN100_BIT] = eee_en_100;
      end
      `IDX_CAP: begin
        rword[`CAP_TEMP_BIT] = INDUSTRIAL_TEMP;
        rword[`CAP_QUAD_BIT] = `CAP_QUAD_VAL;
        rword[`CAP_SEC_BIT] = SEC_CAPABLE;
        rword[`CAP_DUAL_BIT] = DUAL_MEDIA;
        rword[`CAP_KEY256_BIT] = KEY256_CAPABLE;
        rword[7:0] = VARIANT_BCD;
      end
      `IDX_ENT: rword = entropy;
      `IDX_MASK: rword = mask_reg;
      `IDX_STAT: rword = {5'h00, stat_reg};
      default: rword = 16'h0000;
    endcase
    if (!r_hit) begin
      rword = 16'h0000;
    end
  end

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  // address and data are taken in either order, response follows both
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= {`ADDR_W{1'b0}};
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      awready_reg <= ~aw_held_reg & ~(awvalid & awready_reg) &
        ~bvalid_reg & ~w_fire;
      wready_reg <= ~w_held_reg & ~(wvalid & wready_reg) &
        ~bvalid_reg & ~w_fire;
      if (awvalid && awready_reg) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= awaddr;
      end
      if (wvalid && wready_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (w_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= w_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  // one read at a time; data is captured at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else if (r_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0000, rword};
      rresp_reg <= r_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // sticky registers: cleared only by the hardware reset
  // ****************************************************************
  // efficient ethernet debug control and interrupt mask
  always @(posedge aclk) begin
    if (!aresetn) begin
      eee_ctrl_reg <= `EEE_RESET;
      mask_reg <= `MASK_RESET;
    end else if (w_fire && w_hit) begin
      // software reset does not touch these
      if (widx == `IDX_EEE) begin
        eee_ctrl_reg <= merge(eee_ctrl_reg, wval,
          wmask & `EEE_WR_MASK);
      end
      if (widx == `IDX_MASK) begin
        mask_reg <= merge(mask_reg, wval, wmask);
      end
    end
  end

  // ****************************************************************
  // non-sticky registers: page select and basic control
  // ****************************************************************
  // a software reset returns these to default and pulses out
  always @(posedge aclk) begin
    if (!aresetn) begin
      page_reg <= `PAGE_MAIN;
      basic_reg <= `BASIC_RESET;
      soft_rst_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      page_reg <= `PAGE_MAIN;
      basic_reg <= `BASIC_RESET;
      soft_rst_reg <= 1'b0;
    end else if (w_fire && w_hit) begin
      if (widx == `IDX_PAGE) begin
        page_reg <= merge(page_reg, wval, wmask);
      end
      if (widx == `IDX_BASIC) begin
        basic_reg <= merge(basic_reg, wval, wmask);
        soft_rst_reg <= wval[`BASIC_SOFT_RST_BIT] &
          wmask[`BASIC_SOFT_RST_BIT];
      end
    end
  end

  // ****************************************************************
  // pending status, cleared by reading it
  // ****************************************************************
  wire stat_read;

  assign stat_read = r_fire & r_hit & (ridx == `IDX_STAT);

  // a new event in the clearing cycle stays pending
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= `STAT_RESET;
    end else if (stat_read) begin
      stat_reg <= int_events;
    end else begin
      stat_reg <= stat_reg | int_events;
    end
  end

  // ****************************************************************
  // datapath controls
  // ****************************************************************
  wire in_100;
  wire in_1000;
  wire [3:0] pol;
  wire ind_kill;
  wire [1:0] speed_sel;

  assign in_100 = (link_mode == `LINK_MODE_100);
  assign in_1000 = (link_mode == `LINK_MODE_1000);
  assign pol = eee_ctrl_reg[`EEE_POL_HI:`EEE_POL_LO];
  assign speed_sel = {basic_reg[`BASIC_SPD_MSB_BIT],
    basic_reg[`BASIC_SPD_LSB_BIT]};
  // indicators go dark in unidirectional fiber unless enabled
  assign ind_kill = fiber_unidir & ~eee_ctrl_reg[`EEE_LED_UNI_BIT];

  integer i;

  // every output is registered for clean timing at the pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      ten_reg <= 1'b0;
      f1000_reg <= 1'b0;
      gen_lpi_reg <= 1'b0;
      tx_lpi_reg <= 1'b0;
      rx_lpi_reg <= 1'b0;
      ind_reg <= 8'hFF;
      ser_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      ten_reg <= eee_ctrl_reg[`EEE_TE_BIT];
      f1000_reg <= eee_ctrl_reg[`EEE_FORCE1000_BIT] &
        (speed_sel == `SPEED_1000);
      gen_lpi_reg <= eee_ctrl_reg[`EEE_FORCE_LPI_BIT];
      // transmit lpi: generator overrides mac, inhibits per speed
      if (eee_ctrl_reg[`EEE_FORCE_LPI_BIT]) begin
        tx_lpi_reg <= 1'b1;
      end else if (in_100 && eee_ctrl_reg[`EEE_INH100_TX_BIT]) begin
        tx_lpi_reg <= 1'b0;
      end else if (in_1000 && eee_ctrl_reg[`EEE_INH1000_TX_BIT]) begin
        tx_lpi_reg <= 1'b0;
      end else begin
        tx_lpi_reg <= mac_tx_lpi;
      end
      // receive lpi toward the mac, inhibits per speed
      if (in_100 && eee_ctrl_reg[`EEE_INH100_RX_BIT]) begin
        rx_lpi_reg <= 1'b0;
      end else if (in_1000 && eee_ctrl_reg[`EEE_INH1000_RX_BIT]) begin
        rx_lpi_reg <= 1'b0;
      end else begin
        rx_lpi_reg <= mdi_rx_lpi;
      end
      // cleared polarity bit drives active low
      for (i = 0; i < 8; i = i + 1) begin
        ind_reg[i] <= ~((indicator_raw[i] & ~ind_kill) ^
          pol[i / 2]);
      end
      ser_reg <= ~((serial_ind_data & ~ind_kill) ^
        pol[serial_ind_group]);
      irq_reg <= |(stat_reg & mask_reg[`INT_W-1:0]);
    end
  end

  // ****************************************************************
  // output drive
  // ****************************************************************
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign enable_10base_te = ten_reg;
  assign force_1000_no_ms = f1000_reg;
  assign generator_tx_lpi = gen_lpi_reg;
  assign mdi_tx_lpi = tx_lpi_reg;
  assign mac_rx_lpi = rx_lpi_reg;
  assign soft_reset_pulse = soft_rst_reg;
  assign indicator_outputs = ind_reg;
  assign serial_ind_out = ser_reg;
  assign irq = irq_reg;

endmodule // phy_ext_page2_ctrl_regs
`default_nettype wire

// File: phy_ext_page2_ctrl_regs_assertions.sv
// checker for the page 2 control bank: bus answers and lpi pins
// bound onto the bank's top module; sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "phy_ext_page2_defines.vh"

module phy_ext_page2_ctrl_regs_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] link_mode,
  input wire logic mdi_rx_lpi,
  input wire logic mac_rx_lpi,
  input wire logic generator_tx_lpi,
  input wire logic mdi_tx_lpi,
  input wire logic soft_reset_pulse
);
  // ******
  // handshake sequences
  // ******
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // address and data taken on one edge; read taken; bad read address
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  sequence s_rd_bad;
    s_rd_taken ##0 (araddr[1:0] != 2'h0 || araddr[7]);
  endsequence

  // ******
  // assertions
  // ******
  a_wr_answer: assert property (
    s_wr_taken |=> !bvalid ##[1:3] bvalid)
    else $error("write answer out of time");
  a_rd_answer: assert property (
    s_rd_taken |=> rvalid)
    else $error("read answer not one cycle later");
  a_rd_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped or changed");
  a_rd_close: assert property (
    rvalid && rready |=> !rvalid && arready)
    else $error("read answer not closed");
  a_bad_addr: assert property (
    s_rd_bad |=> rresp == `RESP_SLVERR && rdata == 32'h0)
    else $error("bad address not refused");
  a_wr_blocked: assert property (
    bvalid |-> !awready && !wready)
    else $error("new write taken before response");
  a_upper_zero: assert property (
    rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_lpi_force: assert property (
    generator_tx_lpi |-> mdi_tx_lpi)
    else $error("forced lpi not on line");
  a_rx_pass: assert property (
    $past(aresetn) && $past(link_mode) == `LINK_MODE_10
      |-> mac_rx_lpi == $past(mdi_rx_lpi))
    else $error("rx lpi not passed in 10M");
  a_pulse_once: assert property (
    soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
endmodule // phy_ext_page2_ctrl_regs_assertions
`default_nettype wire

// File: mgmt_bus_master.sv
// management master model: one axi4-lite write or read at a time
// assumes the bank answers on aclk and the bench calls its tasks
`timescale 1ns/1ps
`default_nettype none
`include "phy_ext_page2_defines.vh"

module mgmt_bus_master (
  input wire logic aclk,
  output logic [`ADDR_W-1:0] awaddr,
  output logic [2:0] awprot,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [`ADDR_W-1:0] araddr,
  output logic [2:0] arprot,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // idle bus at time zero
  initial begin
    awaddr = 8'h00;
    awprot = 3'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arprot = 3'h0;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // write: both channels offered, each released when taken; the
  // released lines are inverted so a stale value is never seen
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    input int dly, output logic [1:0] r, output bit to);
    int n;
    bit done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 60 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
      if (bvalid && bready) begin
        r = bresp;
        done = 1;
      end
      bready <= (n >= dly) && !done;
    end
    to = !done;
  endtask

  // read: rready is held back dly cycles to stall the answer
  task automatic rd(input logic [7:0] a, input int dly,
    output logic [1:0] r, output logic [31:0] d, output bit to);
    int n;
    bit done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 60 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready) begin
        r = rresp;
        d = rdata;
        done = 1;
      end
      rready <= (n >= dly) && !done;
    end
    to = !done;
  endtask
endmodule // mgmt_bus_master
`default_nettype wire

// File: tb.sv
// top bench for the page 2 control bank and its checker
// assumes the bank, the checker and the bus master compiled first
`timescale 1ns/1ps
`default_nettype none
`include "phy_ext_page2_defines.vh"

module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic link_up, eee_en_1000, eee_en_100, fiber_unidir, mac_tx_lpi;
  logic mdi_rx_lpi, serial_ind_data, ex_tx, ex_rx;
  logic [1:0] link_mode, serial_ind_group, ent_r;
  logic [10:0] int_events;
  logic [7:0] indicator_raw;
  logic [31:0] ent_a, ent_b;
  bit ent_t;
  wire [7:0] awaddr, araddr, indicator_outputs;
  wire [31:0] wdata, rdata;
  wire [2:0] awprot, arprot;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready;
  wire arvalid, arready, rvalid, rready, irq, serial_ind_out;
  wire enable_10base_te, force_1000_no_ms, generator_tx_lpi;
  wire mdi_tx_lpi, mac_rx_lpi, soft_reset_pulse;
  int errors = 0;
  int num_checks = 0;
  int pulses = 0;

  // the bank and the master facing it
  phy_ext_page2_ctrl_regs dut (.*);
  mgmt_bus_master mst (.*);

  // 200 mhz clock
  always #2.5 aclk = ~aclk;

  // counts soft reset pulses seen on the pin
  always @(posedge aclk) if (soft_reset_pulse) pulses <= pulses + 1;

  // ******
  // compare and bus tasks
  // ******
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic hang;
    errors++;
    $display("MISMATCH bus answer expected in time seen none");
    report_and_stop();
  endtask
  task automatic chk_val(input string n, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic e, input logic g);
    chk_val(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask
  function automatic logic [7:0] ba(input logic [4:0] i);
    return {1'b0, i, 2'b00};
  endfunction
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    logic [1:0] r;
    bit t;
    mst.wr(ba(i), d, 0, r, t);
    if (t) hang();
    chk_val("bresp", {30'h0, `RESP_OKAY}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er,
    input logic [15:0] ed);
    logic [1:0] r;
    logic [31:0] d;
    bit t;
    mst.rd(a, 1, r, d, t);
    if (t) hang();
    chk_val("rresp", {30'h0, er}, {30'h0, r});
    chk_val("rdata", {16'h0, ed}, d);
  endtask

  // ******
  // main sequence
  // ******
  initial begin
    link_up = 1'b1;
    eee_en_1000 = 1'b1;
    eee_en_100 = 1'b0;
    fiber_unidir = 1'b0;
    mac_tx_lpi = 1'b1;
    mdi_rx_lpi = 1'b1;
    serial_ind_data = 1'b1;
    serial_ind_group = 2'h2;
    link_mode = `LINK_MODE_10;
    int_events = 11'h000;
    indicator_raw = 8'hA5;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ba(`IDX_EEE), `RESP_SLVERR, 16'h0000);
    wr(`IDX_PAGE, `PAGE_EXT2);
    rd(ba(`IDX_EEE), `RESP_OKAY, 16'h0180);
    rd(ba(`IDX_CAP), `RESP_OKAY, 16'h1542);
    rd(ba(`IDX_MASK), `RESP_OKAY, 16'h0000);
    mst.rd(ba(`IDX_ENT), 0, ent_r, ent_a, ent_t);
    if (ent_t) hang();
    mst.rd(ba(`IDX_ENT), 0, ent_r, ent_b, ent_t);
    if (ent_t) hang();
    chk_pin("entropy moves", 1'b1, ent_a !== ent_b);
    wr(`IDX_MASK, 16'hFFFF);
    rd(ba(`IDX_MASK), `RESP_OKAY, 16'hFFFF);
    wr(`IDX_EEE, 16'hFFFF);
    rd(ba(`IDX_EEE), `RESP_OKAY, 16'hFDBF);
    cyc(1);
    chk_pin("te", 1'b1, enable_10base_te);
    chk_pin("gen lpi", 1'b1, generator_tx_lpi);
    chk_val("ind", 32'hA5, {24'h0, indicator_outputs});
    chk_pin("serial", 1'b1, serial_ind_out);
    wr(`IDX_EEE, 16'h0000);
    cyc(2);
    chk_val("ind", 32'h5A, {24'h0, indicator_outputs});
    chk_pin("serial", 1'b0, serial_ind_out);
    @(posedge aclk) fiber_unidir <= 1'b1;
    cyc(2);
    chk_val("ind", 32'hFF, {24'h0, indicator_outputs});
    wr(`IDX_EEE, 16'h5000);
    cyc(2);
    chk_val("ind", 32'h6A, {24'h0, indicator_outputs});
    chk_pin("serial", 1'b1, serial_ind_out);
    @(posedge aclk) fiber_unidir <= 1'b0;
    // each inhibit bit against both link speeds, mac and line in lpi
    for (int m = 1; m <= 2; m++)
      for (int k = 0; k < 4; k++) begin
        @(posedge aclk) link_mode <= m[1:0];
        wr(`IDX_EEE, 16'h0001 << k);
        cyc(2);
        ex_tx = !((m == 1 && k == 3) || (m == 2 && k == 1));
        ex_rx = !((m == 1 && k == 2) || (m == 2 && k == 0));
        chk_pin("mdi_tx_lpi", ex_tx, mdi_tx_lpi);
        chk_pin("mac_rx_lpi", ex_rx, mac_rx_lpi);
      end
    wr(`IDX_EEE, 16'h0020);
    cyc(2);
    chk_pin("force", 1'b1, force_1000_no_ms);
    wr(`IDX_BASIC, 16'h2040);
    cyc(2);
    chk_pin("force", 1'b0, force_1000_no_ms);
    rd(ba(`IDX_BASIC), `RESP_OKAY, 16'h2040);
    wr(`IDX_MASK, 16'h0002);
    @(posedge aclk) int_events <= 11'h001;
    @(posedge aclk) int_events <= 11'h000;
    cyc(3);
    chk_pin("irq", 1'b0, irq);
    @(posedge aclk) int_events <= 11'h002;
    @(posedge aclk) int_events <= 11'h000;
    cyc(3);
    chk_pin("irq", 1'b1, irq);
    rd(ba(`IDX_STAT), `RESP_OKAY, 16'h0003);
    cyc(2);
    chk_pin("irq", 1'b0, irq);
    wr(`IDX_CAP, 16'h0000);
    rd(ba(`IDX_CAP), `RESP_OKAY, 16'h1542);
    rd(8'h45, `RESP_SLVERR, 16'h0000);
    rd(8'hC4, `RESP_SLVERR, 16'h0000);
    rd(ba(5'h14), `RESP_SLVERR, 16'h0000);
    wr(`IDX_BASIC, 16'h8040);
    cyc(3);
    chk_val("soft pulses", 32'h1, pulses);
    rd(ba(`IDX_EEE), `RESP_SLVERR, 16'h0000);
    rd(ba(`IDX_BASIC), `RESP_OKAY, `BASIC_RESET);
    wr(`IDX_PAGE, `PAGE_EXT2);
    rd(ba(`IDX_MASK), `RESP_OKAY, 16'h0002);
    rd(ba(`IDX_EEE), `RESP_OKAY, 16'h01A0);
    wr(`IDX_EEE, 16'h0000);
    @(posedge aclk) {link_up, eee_en_1000, eee_en_100} <= 3'b001;
    rd(ba(`IDX_EEE), `RESP_OKAY, 16'h0040);
    wr(`IDX_PAGE, `PAGE_MAIN);
    rd(ba(`IDX_MASK), `RESP_SLVERR, 16'h0000);
    @(posedge aclk) aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wr(`IDX_PAGE, `PAGE_EXT2);
    rd(ba(`IDX_MASK), `RESP_OKAY, `MASK_RESET);
    report_and_stop();
  end
endmodule // tb

bind phy_ext_page2_ctrl_regs phy_ext_page2_ctrl_regs_assertions chk (.*);
`default_nettype wire
